// [src/drgs_consts.svh]
`ifndef DRGS_CONSTS_SVH
`define DRGS_CONSTS_SVH
// Register indices; byte address is four times the index
`define DRGS_IDX_DIAG_READY   16'h0528
`define DRGS_IDX_PIN_LEVEL    16'h052A
`define DRGS_ADDR_DIAG_READY  16'h14A0
`define DRGS_ADDR_PIN_LEVEL   16'h14A8
// Block-local control and interrupt registers
`define DRGS_ADDR_IRQ_STAT    16'h14B0
`define DRGS_ADDR_IRQ_MASK    16'h14B4
`define DRGS_ADDR_CTRL        16'h14B8
// Field positions of the ready flags
`define DRGS_BIT_CELL_AUX     0
`define DRGS_BIT_BAL_SWITCH   1
`define DRGS_BIT_BAL_OW       2
`define DRGS_BIT_CELL_OW      3
`define DRGS_BIT_PIN_CMP      4
`define DRGS_BIT_FILTER       5
`define DRGS_NUM_FLAGS        6
// Control register fields
`define DRGS_CTRL_COMP_START  0
`define DRGS_CTRL_MAIN_START  1
`define DRGS_CTRL_FAULT_INJ   2
// Reset values
`define DRGS_RST_DIAG_READY   8'h00
`define DRGS_RST_PIN_LEVEL    8'h00
`define DRGS_RST_IRQ_MASK     8'h00
// Bus answers
`define DRGS_RESP_OKAY        2'b00
`define DRGS_RESP_DECERR      2'b11
`endif

// [src/drgs_pkg.sv]
`default_nettype none
package drgs_pkg;
    // Completion pulses from the comparison engines
    typedef struct packed {
        logic pinCmp;   // GPIO comparison pass done
        logic cellOw;   // Cell open-wire pass done
        logic balOw;    // Balancing open-wire pass done, engine halted
        logic balSw;    // Balancing switch pass done, engine halted
        logic cellAux;  // Cell versus aux-cell pass done
    } drgs_done_t;
endpackage
`default_nettype wire

// [src/drgs_status_regs.sv]
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "drgs_consts.svh"

module drgs_status_regs #(
    parameter int ADDR_W = 16,
    parameter int PINS   = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire drgs_pkg::drgs_done_t engDone,
    input  wire logic              lpfCheckDone,
    input  wire logic              mainRunning,
    input  wire logic [PINS-1:0]   pinLevel,
    input  wire logic [PINS-1:0]   pinIsDigital,
    output logic                   compStartPulse,
    output logic                   mainStartPulse,
    output logic                   filterFaultInject,
    output logic                   irq
);

    localparam int NF = `DRGS_NUM_FLAGS;

    // Latched write address and data channels
    logic [ADDR_W-1:0] awAddr_r;
    logic              awHeld_r;
    logic [31:0]       wData_r;
    logic [3:0]        wStrb_r;
    logic              wHeld_r;
    logic              bValid_r;
    logic [1:0]        bResp_r;
    // Read answer
    logic              rValid_r;
    logic [31:0]       rData_r;
    logic [1:0]        rResp_r;
    // Status and control state
    logic [NF-1:0]     flag_r;            // Ready flags, bits 5..0
    logic [NF-1:0]     setVec;            // Hardware set requests
    logic [NF-1:0]     clrVec;            // Start- and inject-triggered clears
    logic [PINS-1:0]   pinStat_r;         // Pin level mirror
    logic [NF-1:0]     irqStat_r;         // Sticky event bits
    logic [NF-1:0]     irqMask_r;         // One enables the event
    logic              compStart_r;
    logic              mainStart_r;
    logic              faultInj_r;
    logic              injRise;           // Fault inject written 0 to 1
    logic              doWrite;           // Both write halves present
    logic              ctrlWr;            // Low byte write to control
    logic [31:0]       rdMux;
    logic [1:0]        rdResp;

    // Handshake outputs come straight from holding state
    assign s_axi_awready = !awHeld_r && !bValid_r;
    assign s_axi_wready  = !wHeld_r && !bValid_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = !rValid_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;

    assign doWrite = awHeld_r && wHeld_r && !bValid_r;
    assign ctrlWr  = doWrite && wStrb_r[0] && (awAddr_r == ADDR_W'(`DRGS_ADDR_CTRL));

    // Write address capture; freed once the write is applied
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end
        else if (doWrite)
        begin
            awHeld_r <= 1'b0;
        end
    end

    // Write data capture, independent of address order
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end
        else if (doWrite)
        begin
            wHeld_r <= 1'b0;
        end
    end

    // Write response; status registers accept and drop writes
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bValid_r <= 1'b0;
            bResp_r  <= `DRGS_RESP_OKAY;
        end
        else if (doWrite)
        begin
            bValid_r <= 1'b1;
            case (awAddr_r)
                ADDR_W'(`DRGS_ADDR_DIAG_READY),
                ADDR_W'(`DRGS_ADDR_PIN_LEVEL),
                ADDR_W'(`DRGS_ADDR_IRQ_STAT),
                ADDR_W'(`DRGS_ADDR_IRQ_MASK),
                ADDR_W'(`DRGS_ADDR_CTRL): bResp_r <= `DRGS_RESP_OKAY;
                default:                  bResp_r <= `DRGS_RESP_DECERR;
            endcase
        end
        else if (s_axi_bready)
        begin
            bValid_r <= 1'b0;
        end
    end

    // Control: start bits are one-cycle pulses, inject is a level
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            compStart_r <= 1'b0;
            mainStart_r <= 1'b0;
            faultInj_r  <= 1'b0;
        end
        else
        begin
            compStart_r <= ctrlWr && wData_r[`DRGS_CTRL_COMP_START];
            mainStart_r <= ctrlWr && wData_r[`DRGS_CTRL_MAIN_START];
            if (ctrlWr)
            begin
                faultInj_r <= wData_r[`DRGS_CTRL_FAULT_INJ];
            end
        end
    end

    assign compStartPulse    = compStart_r;
    assign mainStartPulse    = mainStart_r;
    assign filterFaultInject = faultInj_r;
    // Inject restarts the filter check, so its flag must drop too
    assign injRise = ctrlWr && wData_r[`DRGS_CTRL_FAULT_INJ] && !faultInj_r;

    // Set sources; done pulses already mean the engine has stopped
    assign setVec[`DRGS_BIT_CELL_AUX]   = engDone.cellAux;
    assign setVec[`DRGS_BIT_BAL_SWITCH] = engDone.balSw;
    assign setVec[`DRGS_BIT_BAL_OW]     = engDone.balOw;
    assign setVec[`DRGS_BIT_CELL_OW]    = engDone.cellOw;
    assign setVec[`DRGS_BIT_PIN_CMP]    = engDone.pinCmp;
    assign setVec[`DRGS_BIT_FILTER]     = lpfCheckDone && mainRunning;

    // Clears follow the written start bit in the same edge as its pulse, or a 0 to 1 inject write for the filter flag
    assign clrVec[`DRGS_BIT_PIN_CMP:0]  = {5{ctrlWr && wData_r[`DRGS_CTRL_COMP_START]}};
    assign clrVec[`DRGS_BIT_FILTER]     = (ctrlWr && wData_r[`DRGS_CTRL_MAIN_START])
                                        || injRise;

    // One flag per bit; a set in the clearing cycle wins
    for (genvar i = 0; i < NF; i++)
    begin : g_flag
        always_ff @(posedge ref_clk)
        begin
            if (rst)
            begin
                flag_r[i] <= 1'(`DRGS_RST_DIAG_READY >> i);
            end
            else
            begin
                flag_r[i] <= setVec[i] || (flag_r[i] && !clrVec[i]);
            end
        end

        // Event bit: flag newly raised; write one clears, set wins
        always_ff @(posedge ref_clk)
        begin
            if (rst)
            begin
                irqStat_r[i] <= 1'b0;
            end
            else
            begin
                irqStat_r[i] <= (setVec[i] && !flag_r[i])
                             || (irqStat_r[i] && !(doWrite && wStrb_r[0] && wData_r[i]
                                 && awAddr_r == ADDR_W'(`DRGS_ADDR_IRQ_STAT)));
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            irqMask_r <= NF'(`DRGS_RST_IRQ_MASK);
        end
        else if (doWrite && wStrb_r[0] && awAddr_r == ADDR_W'(`DRGS_ADDR_IRQ_MASK))
        begin
            irqMask_r <= wData_r[NF-1:0];
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

    // Pin mirror; pins in analog use read low
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pinStat_r <= PINS'(`DRGS_RST_PIN_LEVEL);
        end
        else
        begin
            pinStat_r <= pinLevel & pinIsDigital;
        end
    end

    // Read decode; pure lookup, no side effects on any flag
    always_comb
    begin
        rdMux  = '0;
        rdResp = `DRGS_RESP_OKAY;
        case (s_axi_araddr)
            ADDR_W'(`DRGS_ADDR_DIAG_READY): rdMux[NF-1:0]   = flag_r;
            ADDR_W'(`DRGS_ADDR_PIN_LEVEL):  rdMux[PINS-1:0] = pinStat_r;
            ADDR_W'(`DRGS_ADDR_IRQ_STAT):   rdMux[NF-1:0]   = irqStat_r;
            ADDR_W'(`DRGS_ADDR_IRQ_MASK):   rdMux[NF-1:0]   = irqMask_r;
            ADDR_W'(`DRGS_ADDR_CTRL):       rdMux[`DRGS_CTRL_FAULT_INJ] = faultInj_r;
            default:                        rdResp = `DRGS_RESP_DECERR;
        endcase
    end

    // Read answer registered one cycle after the address is taken
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rValid_r <= 1'b0;
            rData_r  <= '0;
            rResp_r  <= `DRGS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rValid_r <= 1'b1;
            rData_r  <= rdMux;
            rResp_r  <= rdResp;
        end
        else if (s_axi_rready)
        begin
            rValid_r <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_BALOW_SET: assert property (engDone.balOw |=> flag_r[`DRGS_BIT_BAL_OW])
        else $error("balance open-wire ready not set");
    AST_BALSW_SET: assert property (engDone.balSw |=> flag_r[`DRGS_BIT_BAL_SWITCH]
        ##1 (flag_r[`DRGS_BIT_BAL_SWITCH] || compStartPulse))
        else $error("balance switch ready not held");
    AST_CELLAUX_SET: assert property ($rose(flag_r[`DRGS_BIT_CELL_AUX]) |-> $past(engDone.cellAux))
        else $error("cell aux ready rose without completion");
    AST_COMP_CLEAR: assert property (ctrlWr && wData_r[0] && engDone == '0 |=>
        flag_r[4:0] == 5'h00 && compStartPulse)
        else $error("comparison start did not clear flags");
    AST_FILTER_RUN: assert property ($rose(flag_r[`DRGS_BIT_FILTER]) |-> $past(lpfCheckDone && mainRunning))
        else $error("filter ready set while main idle");
    AST_PIN_MIRROR: assert property (##1 pinStat_r == $past(pinLevel & pinIsDigital))
        else $error("pin status does not follow pins");
    AST_RO_IGNORED: assert property (doWrite && awAddr_r == ADDR_W'(`DRGS_ADDR_DIAG_READY)
        && setVec == '0 |=> $stable(flag_r))
        else $error("write altered read-only flags");
    AST_READ_DATA: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ADDR_W'(`DRGS_ADDR_DIAG_READY) && setVec == '0 && clrVec == '0
        |=> s_axi_rvalid && s_axi_rdata[NF-1:0] == flag_r)
        else $error("read returned wrong flags");
    AST_IRQ_LEVEL: assert property ($rose(irqStat_r[0]) && irqMask_r[0] |-> irq)
        else $error("unmasked event not raising interrupt");

    COV_BALOW: cover property (engDone.balOw ##1 flag_r[`DRGS_BIT_BAL_OW]);
    COV_CLEAR: cover property (flag_r[0] ##1 compStartPulse);
    COV_IRQ:   cover property ($rose(irq));
    COV_READ:  cover property (s_axi_rvalid && s_axi_rready);

endmodule // drgs_status_regs

`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "drgs_consts.svh"

module tb;
    // Pin table: level and digital-mode masks, one byte per step
    localparam logic [31:0] PIN_LV = 32'hA5A5_FF3C;
    localparam logic [31:0] PIN_DG = 32'hFF0F_00F0;
    // Generous ceiling; the full run needs well under a thousand cycles
    localparam int          LIMIT  = 5000;

    logic                 ref_clk;          // Block clock, 40 MHz
    logic                 rst;              // Synchronous reset, active high
    logic [15:0]          awAddr;           // Write address channel
    logic                 awValid;
    logic                 awReady;
    logic [31:0]          wData;            // Write data channel
    logic [3:0]           wStrb;
    logic                 wValid;
    logic                 wReady;
    logic [1:0]           bResp;            // Write response channel
    logic                 bValid;
    logic                 bReady;
    logic [15:0]          arAddr;           // Read address channel
    logic                 arValid;
    logic                 arReady;
    logic [31:0]          rData;            // Read data channel
    logic [1:0]           rResp;
    logic                 rValid;
    logic                 rReady;
    drgs_pkg::drgs_done_t engDone;          // Engine completion pulses
    logic                 lpfCheckDone;     // Filter check completion pulse
    logic                 mainRunning;      // Main converter running level
    logic [7:0]           pinLevel;         // Pin levels
    logic [7:0]           pinIsDigital;     // Pin digital-mode enables
    logic                 compStartPulse;
    logic                 mainStartPulse;
    logic                 filterFaultInject;
    logic                 irq;
    int                   badCount;         // Mismatches seen
    int                   checked;          // Comparisons made
    int                   cycles;           // Timeout counter
    int                   compSeen;         // Cycles with comparison start pulse high
    int                   mainSeen;         // Cycles with main start pulse high

    drgs_status_regs dut (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .engDone(engDone), .lpfCheckDone(lpfCheckDone), .mainRunning(mainRunning),
        .pinLevel(pinLevel), .pinIsDigital(pinIsDigital), .compStartPulse(compStartPulse),
        .mainStartPulse(mainStartPulse), .filterFaultInject(filterFaultInject), .irq(irq)
    );

    // Free-running clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task automatic end_of_test();
        $display("Summary: %0d comparisons, %0d mismatches", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Single comparison point; case inequality keeps unknowns from matching
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp)
        begin
            badCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Write with both channels offered together, each released when taken
    task automatic expectWrite(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        bit awDone;
        bit wDone;
        @(posedge ref_clk);
        awAddr  <= a;
        awValid <= 1'b1;
        wData   <= d;
        wStrb   <= 4'hF;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        awDone  = 1'b0;
        wDone   = 1'b0;
        while (!(awDone && wDone))
        begin
            @(posedge ref_clk);
            if (!awDone && awReady === 1'b1)
            begin
                awDone = 1'b1;
                awValid <= 1'b0;
            end
            if (!wDone && wReady === 1'b1)
            begin
                wDone = 1'b1;
                wValid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (bValid !== 1'b1);
        bReady <= 1'b0;
        check({bResp, 32'h0}, {er, 32'h0});
    endtask

    // Read one word and compare data and response together
    task automatic expectRead(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        do @(posedge ref_clk); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge ref_clk); while (rValid !== 1'b1);
        rReady <= 1'b0;
        check({rResp, rData}, {er, e});
    endtask

    // One-cycle completion pulses from the engines and the filter check
    task automatic pulseDone(input logic [4:0] v, input logic lpf);
        @(posedge ref_clk);
        engDone      <= drgs_pkg::drgs_done_t'(v);
        lpfCheckDone <= lpf;
        @(posedge ref_clk);
        engDone      <= '0;
        lpfCheckDone <= 1'b0;
    endtask

    // Reset values and unmapped places
    task automatic testReset();
        expectRead(`DRGS_ADDR_DIAG_READY, 32'h0, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_PIN_LEVEL, 32'h0, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_IRQ_MASK, 32'h0, `DRGS_RESP_OKAY);
        expectRead(16'h1000, 32'h0, `DRGS_RESP_DECERR);
        expectWrite(16'h1004, 32'h0000_00FF, `DRGS_RESP_DECERR);
        $display("test reset done");
    endtask

    // Each engine sets its own flag; reads and writes leave flags alone
    task automatic testFlags();
        logic [31:0] exp;
        exp = '0;
        for (int i = 0; i < 5; i++)
        begin
            pulseDone(5'h01 << i, 1'b0);
            exp[i] = 1'b1;
            expectRead(`DRGS_ADDR_DIAG_READY, exp, `DRGS_RESP_OKAY);
        end
        expectRead(`DRGS_ADDR_DIAG_READY, exp, `DRGS_RESP_OKAY);
        expectWrite(`DRGS_ADDR_DIAG_READY, 32'h0000_0000, `DRGS_RESP_OKAY);
        expectWrite(`DRGS_ADDR_PIN_LEVEL, 32'h0000_00FF, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_DIAG_READY, exp, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_PIN_LEVEL, 32'h0, `DRGS_RESP_OKAY);
        check({33'h0, irq}, 34'h0); // Events stay silent while all masked
        $display("test flags done");
    endtask

    // Filter flag only while main runs; comparison start spares it
    task automatic testFilter();
        mainRunning <= 1'b0;
        pulseDone(5'h00, 1'b1);
        expectRead(`DRGS_ADDR_DIAG_READY, 32'h0000_001F, `DRGS_RESP_OKAY);
        mainRunning <= 1'b1;
        pulseDone(5'h00, 1'b1);
        expectRead(`DRGS_ADDR_DIAG_READY, 32'h0000_003F, `DRGS_RESP_OKAY);
        expectWrite(`DRGS_ADDR_CTRL, 32'h0000_0001, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_DIAG_READY, 32'h0000_0020, `DRGS_RESP_OKAY);
        check({2'h0, compSeen}, 34'h1);
        check({2'h0, mainSeen}, 34'h0);
        expectWrite(`DRGS_ADDR_CTRL, 32'h0000_0002, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_DIAG_READY, 32'h0, `DRGS_RESP_OKAY);
        check({2'h0, mainSeen}, 34'h1);
        check({2'h0, compSeen}, 34'h1);
        pulseDone(5'h00, 1'b1);
        expectWrite(`DRGS_ADDR_CTRL, 32'h0000_0004, `DRGS_RESP_OKAY);
        check({33'h0, filterFaultInject}, 34'h1);
        expectRead(`DRGS_ADDR_DIAG_READY, 32'h0, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_CTRL, 32'h0000_0004, `DRGS_RESP_OKAY);
        expectWrite(`DRGS_ADDR_CTRL, 32'h0000_0000, `DRGS_RESP_OKAY);
        check({33'h0, filterFaultInject}, 34'h0);
        mainRunning <= 1'b0;
        $display("test filter done");
    endtask

    // Pin bits follow the level only where the pin is digital
    task automatic testPins();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            pinLevel     <= PIN_LV[i*8 +: 8];
            pinIsDigital <= PIN_DG[i*8 +: 8];
            expectRead(`DRGS_ADDR_PIN_LEVEL, {24'h0, PIN_LV[i*8 +: 8] & PIN_DG[i*8 +: 8]}, `DRGS_RESP_OKAY);
        end
        $display("test pins done");
    endtask

    // Raise, mask and clear the interrupt
    task automatic testIrq();
        expectWrite(`DRGS_ADDR_CTRL, 32'h0000_0001, `DRGS_RESP_OKAY);
        expectWrite(`DRGS_ADDR_IRQ_STAT, 32'h0000_003F, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_IRQ_STAT, 32'h0, `DRGS_RESP_OKAY);
        expectWrite(`DRGS_ADDR_IRQ_MASK, 32'h0000_0004, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_IRQ_MASK, 32'h0000_0004, `DRGS_RESP_OKAY);
        pulseDone(5'h04, 1'b0);
        pulseDone(5'h01, 1'b0);
        expectRead(`DRGS_ADDR_IRQ_STAT, 32'h0000_0005, `DRGS_RESP_OKAY);
        check({33'h0, irq}, 34'h1);
        expectWrite(`DRGS_ADDR_IRQ_STAT, 32'h0000_0004, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_IRQ_STAT, 32'h0000_0001, `DRGS_RESP_OKAY);
        check({33'h0, irq}, 34'h0); // Remaining bit is masked
        expectWrite(`DRGS_ADDR_IRQ_STAT, 32'h0000_0001, `DRGS_RESP_OKAY);
        expectRead(`DRGS_ADDR_IRQ_STAT, 32'h0, `DRGS_RESP_OKAY);
        check({2'h0, compSeen}, 34'h2);
        $display("test irq done");
    endtask

    // Hang guard: a run past the ceiling counts as a mismatch
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            badCount++;
            end_of_test();
        end
    end

    // Pulse monitor: each start write must give exactly one high cycle
    always @(posedge ref_clk)
    begin
        if (compStartPulse === 1'b1)
            compSeen++;
        if (mainStartPulse === 1'b1)
            mainSeen++;
    end

    // Main sequence
    initial
    begin
        {awAddr, awValid, wData, wStrb, wValid, bReady} = '0;
        {arAddr, arValid, rReady, lpfCheckDone, mainRunning} = '0;
        {pinLevel, pinIsDigital} = '0;
        engDone  = '0;
        badCount = 0;
        checked  = 0;
        cycles   = 0;
        compSeen = 0;
        mainSeen = 0;
        rst      = 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        testReset();
        testFlags();
        testFilter();
        testPins();
        testIrq();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
